/* dtc_pkg.sv */
// Behaviour
// - Counter A equal to compare_a raises irq_timer_a in discrete, carrier and PWM modes.
// - Counter B equal to compare_b_low raises irq_timer_b in discrete mode and in the low phase of carrier and PWM.
// - Cascade: irq_timer_b only on joint match of both halves; never irq_timer_a.
// - Carrier and PWM: compare_b_low sets the low-level width of the output.
// - Carrier and PWM: compare_b_high sets the high-level width of the output.
// - Carrier and PWM: counter B equal to compare_b_high in the high phase raises irq_timer_b.
// - Reset zeroes both counters; software reads them byte-wide only.
// - Compare registers have no reset value; written byte-wide by software.
// - Discrete: counter A clears on reset, enable low, match, overflow.
// - Discrete: counter B clears on reset, enable low, match, overflow.
// - Cascade: both clear together on reset, enable B low, joint match, joint overflow.
// - Carrier and PWM: counter B clears on its matches, overflow, enable low; counter A as in discrete.
// - Carrier mode: timer A periods gate timer B's carrier onto the output.
// - Cascade: counters form one 16-bit timer, counter A the low half.
// - Discrete: both are interval timers; only B counts events and drives square wave.
// - PWM: timer B drives a pulse train whose duty comes from its compares.
// - Mode decodes from both mode fields: 0000, 0101, 0011, 0010; others prohibited.
// - Cascade: count_enable_b starts and clears both; count_enable_a is ignored.
// - Cascade: counter A counts on timer B's count clock, whatever A selects.
package dtc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [5:0] ADDR_MODE_A    = 6'h00;
	localparam logic [5:0] ADDR_MODE_B    = 6'h04;
	localparam logic [5:0] ADDR_CARRIER   = 6'h08;
	localparam logic [5:0] ADDR_CMP_A     = 6'h0C;
	localparam logic [5:0] ADDR_CMP_B_LOW = 6'h10;
	localparam logic [5:0] ADDR_CMP_B_HI  = 6'h14;
	localparam logic [5:0] ADDR_CNT_A     = 6'h18;
	localparam logic [5:0] ADDR_CNT_B     = 6'h1C;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, masks, field positions
	localparam logic [7:0] CNT_RESET      = 8'h00;
	localparam logic [7:0] CNT_MAX        = 8'hFF;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [7:0] MODE_A_MASK    = 8'hBE;
	localparam logic [7:0] MODE_B_MASK    = 8'hBF;
	localparam logic [2:0] CARRIER_MASK   = 3'h7;
	localparam int         CAR_NRZ_BIT    = 0;
	localparam int         CAR_NRZB_BIT   = 1;
	localparam int         CAR_FORCE_BIT  = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Count clock selections and prescaler spans (in cycles, as powers of two)
	localparam logic [2:0] CSA_DIV_LO     = 3'h0;
	localparam logic [2:0] CSA_DIV_HI     = 3'h1;
	localparam logic [2:0] CSA_B_MATCH    = 3'h2;
	localparam logic [2:0] CSA_CARRIER    = 3'h3;
	localparam logic [2:0] CSB_FCLK       = 3'h0;
	localparam logic [2:0] CSB_DIV4       = 3'h1;
	localparam logic [2:0] CSB_EXT        = 3'h2;
	localparam logic [2:0] CSB_EXT_DIV2   = 3'h3;
	localparam logic [2:0] CSB_EXT_DIV4   = 3'h4;
	localparam logic [2:0] CSB_EXT_DIV8   = 3'h5;
	localparam int         PRE_A_LO_BITS  = 6;
	localparam int         PRE_A_HI_BITS  = 8;
	localparam int         PRE_B_BITS     = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Mode codes {sel_a_hi, sel_a_lo, sel_b_hi, sel_b_lo}
	localparam logic [3:0] MCODE_DISCRETE = 4'h0;
	localparam logic [3:0] MCODE_CASCADE  = 4'h5;
	localparam logic [3:0] MCODE_CARRIER  = 4'h3;
	localparam logic [3:0] MCODE_PWM      = 4'h2;

	typedef struct packed {
		logic       countEnable;
		logic       zero6;
		logic [2:0] clkSel;
		logic       modeSelHi;
		logic       modeSelLo;
		logic       outEnable;
	} dtc_mode_ctrl_t;

	typedef enum {OP_DISCRETE, OP_CASCADE, OP_CARRIER, OP_PWM, OP_PROHIBITED} dtc_opmode_t;

	typedef enum {PH_LOW, PH_HIGH} dtc_phase_t;

endpackage

/* dtc_timer.sv */
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
module dtc_timer
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Pins and events
	input  wire logic        eventIn,
	output logic             timerOutputPin,
	output logic             irqTimerA,
	output logic             irqTimerB
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rstMeta_reg;
	logic rstSyncB;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_reg <= 1'b0;
			rstSyncB    <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSyncB    <= rstMeta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	dtc_mode_ctrl_t modeCtrlA_reg;
	dtc_mode_ctrl_t modeCtrlB_reg;
	logic [2:0]     carrierCtrl_reg;
	logic [7:0]     compareA_reg;
	logic [7:0]     compareBLow_reg;
	logic [7:0]     compareBHigh_reg;
	logic [7:0]     cntA_reg;
	logic [7:0]     cntA_next;
	logic [7:0]     cntB_reg;
	logic [7:0]     cntB_next;
	dtc_phase_t     phase_reg;
	dtc_phase_t     phase_next;
	logic           square_reg;
	logic           nrz_reg;
	logic           ack_reg;
	logic [31:0]    rdata_reg;
	logic           busReq;
	logic           wrEn;
	logic           irqANext;
	logic           irqBNext;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave: waitrequest drops in the second cycle of every request
	assign busReq          = avs_read | avs_write;
	assign avs_waitrequest = busReq & ~ack_reg;
	assign wrEn            = avs_write & ack_reg & avs_byteenable[0];
	assign avs_readdata    = rdata_reg;
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= busReq & ~ack_reg;
		end
	end

	// Read data sampled a cycle early so it stands when waitrequest drops
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			rdata_reg <= 32'h0000_0000;
		end else if (avs_read & ~ack_reg) begin
			rdata_reg <= 32'h0000_0000;
			if (avs_byteenable[0]) begin
				case (avs_address)
					ADDR_MODE_A:    rdata_reg[7:0] <= modeCtrlA_reg;
					ADDR_MODE_B:    rdata_reg[7:0] <= modeCtrlB_reg;
					ADDR_CARRIER:   rdata_reg[2:0] <= carrierCtrl_reg;
					ADDR_CMP_A:     rdata_reg[7:0] <= compareA_reg;
					ADDR_CMP_B_LOW: rdata_reg[7:0] <= compareBLow_reg;
					ADDR_CMP_B_HI:  rdata_reg[7:0] <= compareBHigh_reg;
					ADDR_CNT_A:     rdata_reg[7:0] <= cntA_reg;
					ADDR_CNT_B:     rdata_reg[7:0] <= cntB_reg;
					default:        rdata_reg      <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			modeCtrlA_reg   <= CTRL_RESET;
			modeCtrlB_reg   <= CTRL_RESET;
			carrierCtrl_reg <= 3'h0;
		end else if (wrEn) begin
			case (avs_address)
				ADDR_MODE_A:  modeCtrlA_reg   <= avs_writedata[7:0] & MODE_A_MASK;
				ADDR_MODE_B:  modeCtrlB_reg   <= avs_writedata[7:0] & MODE_B_MASK;
				ADDR_CARRIER: carrierCtrl_reg <= avs_writedata[2:0] & CARRIER_MASK;
				default:      modeCtrlA_reg   <= modeCtrlA_reg;
			endcase
		end
	end
	// No reset here on purpose: contents stay unknown until written
	always_ff @(posedge clk_sys) begin
		if (wrEn && avs_address == ADDR_CMP_A) begin
			compareA_reg <= avs_writedata[7:0];
		end
		if (wrEn && avs_address == ADDR_CMP_B_LOW) begin
			compareBLow_reg <= avs_writedata[7:0];
		end
		if (wrEn && avs_address == ADDR_CMP_B_HI) begin
			compareBHigh_reg <= avs_writedata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode
	dtc_opmode_t opMode;
	logic [3:0]  modeCode;
	assign modeCode = {modeCtrlA_reg.modeSelHi, modeCtrlA_reg.modeSelLo,
		modeCtrlB_reg.modeSelHi, modeCtrlB_reg.modeSelLo};
	always_comb begin
		case (modeCode)
			MCODE_DISCRETE: opMode = OP_DISCRETE;
			MCODE_CASCADE:  opMode = OP_CASCADE;
			MCODE_CARRIER:  opMode = OP_CARRIER;
			MCODE_PWM:      opMode = OP_PWM;
			default:        opMode = OP_PROHIBITED;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event input: three flops, an edge counts once the last two agree
	logic       extS1_reg;
	logic       extS2_reg;
	logic       extS3_reg;
	logic       extLevel_reg;
	logic       extRise;
	logic [2:0] extDiv_reg;
	assign extRise = (extS2_reg == extS3_reg) & extS3_reg & ~extLevel_reg;
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			extS1_reg    <= 1'b0;
			extS2_reg    <= 1'b0;
			extS3_reg    <= 1'b0;
			extLevel_reg <= 1'b0;
		end else begin
			extS1_reg <= eventIn;
			extS2_reg <= extS1_reg;
			extS3_reg <= extS2_reg;
			if (extS2_reg == extS3_reg) begin
				extLevel_reg <= extS3_reg;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			extDiv_reg <= 3'h0;
		end else if (extRise) begin
			extDiv_reg <= extDiv_reg + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler and count clock ticks
	logic [7:0] pre_reg;
	logic       tickA;
	logic       tickB;
	logic       carrierEdge;
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			pre_reg <= 8'h00;
		end else begin
			pre_reg <= pre_reg + 8'h01;
		end
	end
	// Carrier rising edge: start of a high phase
	assign carrierEdge = (phase_reg == PH_LOW) && (phase_next == PH_HIGH);
	always_comb begin
		case (modeCtrlB_reg.clkSel)
			CSB_FCLK:     tickB = 1'b1;
			CSB_DIV4:     tickB = &pre_reg[PRE_B_BITS-1:0];
			CSB_EXT:      tickB = extRise;
			CSB_EXT_DIV2: tickB = extRise & extDiv_reg[0];
			CSB_EXT_DIV4: tickB = extRise & (&extDiv_reg[1:0]);
			CSB_EXT_DIV8: tickB = extRise & (&extDiv_reg);
			default:      tickB = 1'b0;
		endcase
	end

	always_comb begin
		if (opMode == OP_CASCADE) begin
			tickA = tickB;
		end else begin
			case (modeCtrlA_reg.clkSel)
				CSA_DIV_LO:  tickA = &pre_reg[PRE_A_LO_BITS-1:0];
				CSA_DIV_HI:  tickA = &pre_reg[PRE_A_HI_BITS-1:0];
				CSA_B_MATCH: tickA = irqTimerB;
				CSA_CARRIER: tickA = carrierEdge;
				default:     tickA = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter next state
	logic enA;
	logic enB;
	logic bothMatch;
	logic bothMax;
	logic [7:0] limitB;
	assign enA       = modeCtrlA_reg.countEnable;
	assign enB       = modeCtrlB_reg.countEnable;
	assign bothMatch = (cntA_reg == compareA_reg) && (cntB_reg == compareBLow_reg);
	assign bothMax   = (cntA_reg == CNT_MAX) && (cntB_reg == CNT_MAX);
	assign limitB    = (phase_reg == PH_HIGH) ? compareBHigh_reg : compareBLow_reg;
	always_comb begin
		cntA_next  = cntA_reg;
		cntB_next  = cntB_reg;
		phase_next = phase_reg;
		irqANext   = 1'b0;
		irqBNext   = 1'b0;
		// Timer A alone in discrete, carrier and PWM; compare_a unused by PWM output
		if (opMode == OP_DISCRETE || opMode == OP_CARRIER || opMode == OP_PWM) begin
			if (!enA) begin
				cntA_next = CNT_RESET;
			end else if (tickA) begin
				if (cntA_reg == compareA_reg) begin
					cntA_next = CNT_RESET;
					irqANext  = 1'b1;
				end else if (cntA_reg == CNT_MAX) begin
					cntA_next = CNT_RESET;
				end else begin
					cntA_next = cntA_reg + 8'h01;
				end
			end
		end
		case (opMode)
			OP_DISCRETE: begin
				if (!enB) begin
					cntB_next = CNT_RESET;
				end else if (tickB) begin
					if (cntB_reg == compareBLow_reg) begin
						cntB_next = CNT_RESET;
						irqBNext  = 1'b1;
					end else if (cntB_reg == CNT_MAX) begin
						cntB_next = CNT_RESET;
					end else begin
						cntB_next = cntB_reg + 8'h01;
					end
				end
			end
			OP_CASCADE: begin
				// count_enable_a has no say here
				if (!enB) begin
					cntA_next = CNT_RESET;
					cntB_next = CNT_RESET;
				end else if (tickB) begin
					if (bothMatch || bothMax) begin
						cntA_next = CNT_RESET;
						cntB_next = CNT_RESET;
						irqBNext  = bothMatch;
					end else begin
						cntA_next = cntA_reg + 8'h01;
						if (cntA_reg == CNT_MAX) begin
							cntB_next = cntB_reg + 8'h01;
						end
					end
				end
			end
			OP_CARRIER, OP_PWM: begin
				if (!enB) begin
					cntB_next  = CNT_RESET;
					phase_next = PH_LOW;
				end else if (tickB) begin
					if (cntB_reg == limitB) begin
						cntB_next  = CNT_RESET;
						irqBNext   = 1'b1;
						phase_next = (phase_reg == PH_HIGH) ? PH_LOW : PH_HIGH;
					end else if (cntB_reg == CNT_MAX) begin
						cntB_next = CNT_RESET;
					end else begin
						cntB_next = cntB_reg + 8'h01;
					end
				end
			end
			default: begin
				// Prohibited code: both halted rather than guessing a mode
				cntA_next  = CNT_RESET;
				cntB_next  = CNT_RESET;
				phase_next = PH_LOW;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			cntA_reg <= CNT_RESET;
			cntB_reg <= CNT_RESET;
		end else begin
			cntA_reg <= cntA_next;
			cntB_reg <= cntB_next;
		end
	end
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			phase_reg <= PH_LOW;
			irqTimerA <= 1'b0;
			irqTimerB <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			irqTimerA <= irqANext;
			irqTimerB <= irqBNext;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output waveform
	logic waveLevel;
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			square_reg <= 1'b0;
		end else if ((opMode == OP_DISCRETE || opMode == OP_CASCADE) && irqBNext) begin
			square_reg <= ~square_reg;
		end
	end

	// Gate level reloaded at each timer A period; a write sets it at once
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			nrz_reg <= 1'b0;
		end else if (wrEn && avs_address == ADDR_CARRIER) begin
			nrz_reg <= avs_writedata[CAR_NRZ_BIT];
		end else if (opMode == OP_CARRIER && irqANext) begin
			nrz_reg <= carrierCtrl_reg[CAR_NRZB_BIT];
		end
	end

	always_comb begin
		case (opMode)
			OP_CARRIER: waveLevel = nrz_reg &
				(carrierCtrl_reg[CAR_FORCE_BIT] | (phase_reg == PH_HIGH));
			OP_PWM:     waveLevel = (phase_reg == PH_HIGH);
			default:    waveLevel = square_reg;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			timerOutputPin <= 1'b0;
		end else begin
			timerOutputPin <= modeCtrlB_reg.outEnable & waveLevel;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstSyncB);
	irq_a_match_a: assert property (opMode == OP_DISCRETE && enA && tickA
		&& cntA_reg == compareA_reg |=> irqTimerA && cntA_reg == CNT_RESET) else $error("A missed");
	irq_b_match_a: assert property (opMode == OP_DISCRETE && enB && tickB
		&& cntB_reg == compareBLow_reg |=> irqTimerB && cntB_reg == CNT_RESET) else $error("B missed");
	casc_no_irqa_a: assert property (opMode == OP_CASCADE |-> !irqANext)
		else $error("irq A in cascade");
	casc_joint_a: assert property (opMode == OP_CASCADE && enB && tickB && bothMatch
		|=> irqTimerB && cntA_reg == CNT_RESET && cntB_reg == CNT_RESET) else $error("joint missed");
	pwm_low_end_a: assert property (opMode == OP_PWM && enB && tickB && phase_reg == PH_LOW
		&& cntB_reg == compareBLow_reg |=> phase_reg == PH_HIGH && irqTimerB) else $error("low width");
	pwm_high_end_a: assert property (opMode == OP_PWM && enB && tickB && phase_reg == PH_HIGH
		&& cntB_reg == compareBHigh_reg |=> phase_reg == PH_LOW && irqTimerB) else $error("high width");
	disc_clear_a: assert property (opMode == OP_DISCRETE && !enA |=> cntA_reg == CNT_RESET)
		else $error("A not cleared");
	casc_stop_a: assert property (opMode == OP_CASCADE && !enB |=> cntA_reg == CNT_RESET
		&& cntB_reg == CNT_RESET) else $error("cascade not cleared");
	casc_carry_a: assert property (opMode == OP_CASCADE && enB && tickB && cntA_reg == CNT_MAX
		&& !bothMatch && !bothMax |=> cntB_reg == $past(cntB_reg) + 8'h01) else $error("carry lost");
	pwm_pin_a: assert property (opMode == OP_PWM && modeCtrlB_reg.outEnable
		|=> timerOutputPin == $past(phase_reg == PH_HIGH)) else $error("pwm pin wrong");
	bus_answer_a: assert property (busReq && avs_waitrequest |=> !avs_waitrequest)
		else $error("slow answer");

	casc_irq_c: cover property (opMode == OP_CASCADE && irqTimerB);
	pwm_cycle_c: cover property (opMode == OP_PWM && carrierEdge);
	carrier_gate_c: cover property (opMode == OP_CARRIER && $rose(nrz_reg));
	ext_event_c: cover property (extRise && tickB);

endmodule

/* dtc_far_side.sv */
module dtc_far_side (
	// Clock
	input  wire logic        clk_sys,
	// Event burst request
	input  wire logic [7:0]  pulseNum,
	input  wire logic        pulseGo,
	// Pins
	output logic             eventIn,
	input  wire logic        timerOutputPin,
	output logic      [15:0] pinHighCycles
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] leftReg;
	logic [2:0] phaseReg;

	initial begin
		eventIn = 1'b0;
		leftReg = 8'h00;
		phaseReg = 3'h0;
		pinHighCycles = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Whole pulses only: 4 low, 4 high, so the 3-flop synchroniser never misses one
	always @(posedge clk_sys) begin
		phaseReg <= pulseGo ? 3'h0 : phaseReg + 3'h1;
		if (pulseGo) begin
			leftReg <= pulseNum;
		end else if (phaseReg == 3'h7 && leftReg != 8'h00) begin
			leftReg <= leftReg - 8'h01;
		end
		eventIn <= (leftReg != 8'h00) && phaseReg[2] && !pulseGo;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Load side: counts cycles the output pin sits high
	always @(posedge clk_sys) begin
		if (timerOutputPin === 1'b1) begin
			pinHighCycles <= pinHighCycles + 16'h0001;
		end
	end
endmodule

/* tb_top.sv */
module tb_top
	import dtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys, rst_b, avs_read, avs_write, avs_waitrequest;
	logic        eventIn, timerOutputPin, irqTimerA, irqTimerB, pulseGo;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic [7:0]  pulseNum, rd;
	logic [15:0] pinHighCycles, h0;
	int          failures, numChecks, aPulses, a0, g;

	dtc_timer dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .eventIn(eventIn),
		.timerOutputPin(timerOutputPin), .irqTimerA(irqTimerA), .irqTimerB(irqTimerB));

	dtc_far_side far_u (.clk_sys(clk_sys), .pulseNum(pulseNum), .pulseGo(pulseGo),
		.eventIn(eventIn), .timerOutputPin(timerOutputPin), .pinHighCycles(pinHighCycles));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (irqTimerA === 1'b1) begin
			aPulses++;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		numChecks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task chkn(input string what, input int exp, input int got);
		numChecks++;
		if (got != exp) begin
			failures++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Held until waitrequest is sampled low; no latency assumed
	task av(input logic isWr, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= !isWr;
		avs_write <= isWr;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= 4'h1;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task wr(input logic [5:0] a, input logic [7:0] d);
		av(1'b1, a, d);
	endtask

	task rdc(input string what, input logic [5:0] a, input logic [7:0] exp);
		av(1'b0, a, 8'h00);
		chk8(what, exp, rd);
	endtask

	// Cycles between two successive interrupt pulses
	task irq_gap(input logic useB, output int n);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while ((useB ? irqTimerB : irqTimerA) !== 1'b1 && k < 2000);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while ((useB ? irqTimerB : irqTimerA) !== 1'b1 && n < 2000);
	endtask

	// Length of one whole run of the pin at the given level
	task run_len(input logic lvl, output int n);
		int k;
		k = 0;
		while (timerOutputPin !== !lvl && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		while (timerOutputPin !== lvl && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		n = 0;
		while (timerOutputPin === lvl && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	task high_over(input int cyc, input int exp);
		repeat (10) @(posedge clk_sys);
		h0 = pinHighCycles;
		repeat (cyc) @(posedge clk_sys);
		chkn("pin high cycles", exp, int'(pinHighCycles - h0));
	endtask

	// Event burst, then room for the synchroniser to pass the last edge
	task pulses(input logic [7:0] n);
		pulseNum <= n;
		pulseGo <= 1'b1;
		@(posedge clk_sys);
		pulseGo <= 1'b0;
		repeat (70) @(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		tally_and_finish();
	end

	initial begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		pulseNum = 8'h00;
		pulseGo = 1'b0;
		failures = 0;
		numChecks = 0;
		aPulses = 0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk_sys);
		// Reset values, read-only counters, unmapped space
		rdc("counter a", ADDR_CNT_A, 8'h00);
		rdc("counter b", ADDR_CNT_B, 8'h00);
		wr(ADDR_CNT_A, 8'h55);
		rdc("counter a after write", ADDR_CNT_A, 8'h00);
		rdc("unmapped", 6'h20, 8'h00);
		wr(ADDR_CMP_A, 8'h5A);
		rdc("compare a", ADDR_CMP_A, 8'h5A);
		$display("test reset done");
		// Discrete: A on clk/64, B on every clock with square wave
		wr(ADDR_CMP_A, 8'h03);
		wr(ADDR_MODE_A, 8'h80);
		irq_gap(1'b0, g);
		chkn("irq a gap", 256, g);
		wr(ADDR_MODE_A, 8'h88);
		irq_gap(1'b0, g);
		chkn("irq a div256 gap", 1024, g);
		wr(ADDR_MODE_A, 8'h00);
		rdc("counter a disabled", ADDR_CNT_A, 8'h00);
		wr(ADDR_CMP_B_LOW, 8'h05);
		wr(ADDR_MODE_B, 8'h81);
		irq_gap(1'b1, g);
		chkn("irq b gap", 6, g);
		run_len(1'b1, g);
		chkn("square high", 6, g);
		wr(ADDR_MODE_B, 8'h89);
		irq_gap(1'b1, g);
		chkn("irq b div4 gap", 24, g);
		wr(ADDR_MODE_A, 8'h90);
		irq_gap(1'b0, g);
		chkn("irq a on b match gap", 96, g);
		wr(ADDR_MODE_A, 8'h00);
		wr(ADDR_MODE_B, 8'h00);
		rdc("counter b disabled", ADDR_CNT_B, 8'h00);
		$display("test discrete done");
		// Cascade: enable A left off, B alone starts both halves
		wr(ADDR_CMP_B_LOW, 8'h01);
		wr(ADDR_MODE_A, 8'h02);
		wr(ADDR_MODE_B, 8'h83);
		a0 = aPulses;
		irq_gap(1'b1, g);
		chkn("joint gap", 260, g);
		chkn("irq a in cascade", 0, aPulses - a0);
		wr(ADDR_MODE_B, 8'h02);
		rdc("cascade low cleared", ADDR_CNT_A, 8'h00);
		rdc("cascade high cleared", ADDR_CNT_B, 8'h00);
		wr(ADDR_MODE_A, 8'h00);
		$display("test cascade done");
		// PWM: compare_a left stale on purpose, output from B only
		wr(ADDR_CMP_B_LOW, 8'h03);
		wr(ADDR_CMP_B_HI, 8'h01);
		wr(ADDR_MODE_B, 8'h85);
		run_len(1'b1, g);
		chkn("pwm high", 2, g);
		run_len(1'b0, g);
		chkn("pwm low", 4, g);
		$display("test pwm done");
		// Carrier: gate passes the carrier, force holds high, gate off blocks
		wr(ADDR_MODE_B, 8'h87);
		wr(ADDR_CARRIER, 8'h01);
		high_over(96, 32);
		wr(ADDR_CARRIER, 8'h05);
		high_over(100, 100);
		wr(ADDR_CARRIER, 8'h00);
		high_over(100, 0);
		wr(ADDR_MODE_A, 8'h98);
		wr(ADDR_CARRIER, 8'h02);
		irq_gap(1'b0, g);
		chkn("gate period", 24, g);
		high_over(96, 32);
		wr(ADDR_MODE_A, 8'h00);
		wr(ADDR_MODE_B, 8'h00);
		$display("test carrier done");
		// External events on B
		wr(ADDR_CMP_B_LOW, 8'hFF);
		wr(ADDR_MODE_B, 8'h90);
		pulses(8'h05);
		rdc("event count", ADDR_CNT_B, 8'h05);
		wr(ADDR_MODE_B, 8'h00);
		rdc("event count cleared", ADDR_CNT_B, 8'h00);
		wr(ADDR_MODE_B, 8'h98);
		pulses(8'h06);
		rdc("event half count", ADDR_CNT_B, 8'h03);
		wr(ADDR_MODE_B, 8'h00);
		$display("test event done");
		// Prohibited mode code clears and stops both counters
		wr(ADDR_MODE_A, 8'h80);
		wr(ADDR_MODE_B, 8'h83);
		repeat (300) @(posedge clk_sys);
		rdc("prohibited a", ADDR_CNT_A, 8'h00);
		rdc("prohibited b", ADDR_CNT_B, 8'h00);
		$display("test prohibited done");
		tally_and_finish();
	end
endmodule
